// ### include/bst_pkg.sv
// Package: register map, field layout and types of the breaker status bank
package bst_pkg;

  // Register indexes; the byte address on APB is four times the index
  localparam logic [7:0] IDX_PROFILE_STATUS   = 8'hDA;
  localparam logic [7:0] IDX_INST_TRIP_COUNT  = 8'hDB;
  localparam logic [7:0] IDX_SHORT_TRIP_COUNT = 8'hDC;
  localparam logic [7:0] IDX_OVLD_TRIP_COUNT  = 8'hDD;
  localparam logic [7:0] IDX_NEUT_TRIP_COUNT  = 8'hDE;
  localparam logic [7:0] IDX_EVENT_STATUS     = 8'hF0;
  localparam logic [7:0] IDX_EVENT_MASK       = 8'hF1;

  // Profile status word field positions
  localparam int BIT_LIMIT      = 0;
  localparam int BIT_ALARM      = 1;
  localparam int BIT_WPROT      = 2;
  localparam int POS_CAUSE_LO   = 4;
  localparam int BIT_LOADSHED   = 7;
  localparam int POS_POSITION   = 8;
  localparam int POS_SWITCH     = 10;
  localparam int BIT_SPRING     = 14;
  localparam int BIT_OVLD_ALARM = 15;

  // Register widths and number of counters
  localparam int REG_W   = 16;
  localparam int COUNT_W = 8;
  localparam int NUM_CNT = 4;
  localparam int EVT_W   = 5;

  // Event status bit positions (one per counter, plus other trips)
  localparam int EVT_INST  = 0;
  localparam int EVT_SHORT = 1;
  localparam int EVT_OVLD  = 2;
  localparam int EVT_NEUT  = 3;
  localparam int EVT_OTHER = 4;

  // Values after reset, and the counter ceiling
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_MAX   = 8'hFF;
  localparam logic [EVT_W-1:0]   MASK_RESET  = 5'h00;
  localparam logic [EVT_W-1:0]   EVT_RESET   = 5'h00;

  // Cause of the most recent trip
  typedef enum logic [2:0] {
    CAUSE_NONE     = 3'h0,
    CAUSE_OVERLOAD = 3'h1,
    CAUSE_INST     = 3'h2,
    CAUSE_SHORT    = 3'h3,
    CAUSE_GROUND   = 3'h4,
    CAUSE_EXTENDED = 3'h5,
    CAUSE_NEUTRAL  = 3'h6,
    CAUSE_RSVD     = 3'h7
  } bst_cause_t;

  // Live breaker conditions from the protection logic
  typedef struct packed {
    logic       limit_reached;   // A configured limit has been reached
    logic       alarm_active;    // At least one alarm is active
    logic       write_protect;   // Write protection in force
    logic       load_shed_alarm; // Load shedding alarm present
    logic [1:0] position;        // 0 disc, 1 operating, 2 test, 3 absent
    logic [1:0] switch_state;    // 0 not ready, 1 off, 2 on, 3 tripped
    logic       spring_charged;  // Spring energy store compressed
    logic       overload_alarm;  // Overload alarm present
  } bst_cond_t;

  // Trip event from the protection logic
  typedef struct packed {
    logic       valid;           // One-cycle pulse per trip
    bst_cause_t cause;           // Reason for that trip
  } bst_trip_t;

  // APB answer phase, one-hot
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b01,
    PH_ANSWER = 2'b10
  } bst_phase_t;

endpackage : bst_pkg

// ### hdl/bst_trip_counters.sv
// Saturating trip counters, one per counted trip kind
`timescale 1ns/1ps
module bst_trip_counters #(
  parameter int N = bst_pkg::NUM_CNT,    // Number of counters
  parameter int W = bst_pkg::COUNT_W     // Counter width
) (
  input  wire logic             clk,     // System clock
  input  wire logic             rst,     // Synchronous reset, active high
  input  wire logic [N-1:0]     inc,     // One-cycle increment per counter
  output logic [N-1:0][W-1:0]   count    // Registered counter values
);

  // All state of this module
  typedef struct packed {
    logic [N-1:0][W-1:0] cnt;            // Counter values
  } bst_cnt_state_t;

  bst_cnt_state_t      state_reg;        // Registered state
  bst_cnt_state_t      state_next;       // Next state
  logic [N-1:0][W-1:0] cnt_step;         // Per-counter next value

  // Each counter stops at full scale so it never wraps back to zero
  generate
    for (genvar i = 0; i < N; i++) begin : g_cnt
      assign cnt_step[i] = (inc[i] && state_reg.cnt[i] != {W{1'b1}})
                           ? W'(state_reg.cnt[i] + 1'b1) // [R11] [R12]
                           : state_reg.cnt[i];           // [R13] [R14]
    end
  endgenerate

  // Next state
  always_comb begin
    state_next     = state_reg;
    state_next.cnt = cnt_step;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.cnt <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.cnt;

endmodule : bst_trip_counters

// ### hdl/bst_status_bank.sv
// APB register bank with breaker profile status and trip counters
//
// Function
// [R1] Read-only profile status word at 0x00DA
// [R2] Bit 0 shows limit reached
// [R3] Bit 1 shows an active alarm
// [R4] Bit 2 shows write protection
// [R5] Bits 4-6 hold last trip cause
// [R6] Bit 7 shows load shedding alarm
// [R7] Bits 8-9 hold breaker position
// [R8] Bits 10-11 hold switching state
// [R9] Bit 14 shows spring store charged
// [R10] Bit 15 shows overload alarm
// [R11] Instantaneous trip count at 0x00DB, 0-255
// [R12] Short delayed trip count at 0x00DC, 0-255
// [R13] Overload trip count at 0x00DD, 0-255
// [R14] Neutral overload trip count at 0x00DE, 0-255
// [R15] Reserved bits zero; writes change nothing
`timescale 1ns/1ps
module bst_status_bank #(
  parameter int ADDR_W = 12                 // APB address width
) (
  input  wire logic              clk,       // System clock, 100 MHz
  input  wire logic              rst,       // Synchronous reset, high
  input  wire logic              psel,      // APB select
  input  wire logic              penable,   // APB access phase
  input  wire logic              pwrite,    // APB write when high
  input  wire logic [ADDR_W-1:0] paddr,     // APB byte address
  input  wire logic [31:0]       pwdata,    // APB write data
  output logic [31:0]            prdata,    // APB read data
  output logic                   pready,    // APB ready
  output logic                   pslverr,   // APB error
  input  wire bst_pkg::bst_cond_t cond,     // Live breaker conditions
  input  wire bst_pkg::bst_trip_t trip,     // Trip event pulse and cause
  output logic                   irq        // Level interrupt
);

  // All state of the bank, registered as one word
  typedef struct packed {
    bst_pkg::bst_phase_t          phase;      // APB answer phase
    logic                         pready;     // Ready toward the master
    logic                         pslverr;    // Error toward the master
    logic [31:0]                  prdata;     // Read data toward master
    logic                         irq;        // Interrupt output
    logic [bst_pkg::EVT_W-1:0]    evt_mask;   // Event enables
    logic [bst_pkg::EVT_W-1:0]    evt_stat;   // Sticky event flags
    logic [bst_pkg::EVT_W-1:0]    evt_shown;  // Flags returned by a read
    bst_pkg::bst_cause_t          last_cause; // Cause of last trip
  } bst_state_t;

  bst_state_t state_reg;                    // Registered state
  bst_state_t state_next;                   // Next state

  // Counter interface
  logic [bst_pkg::NUM_CNT-1:0]                      cnt_inc;  // Increments
  logic [bst_pkg::NUM_CNT-1:0][bst_pkg::COUNT_W-1:0] cnt_val; // Values

  // Decoded request
  logic [7:0]                 req_idx;      // Register index
  logic                       req_ok;       // Aligned and in range
  logic                       req_commit;   // Edge where access ends
  logic [bst_pkg::REG_W-1:0]  profile_word; // Assembled status word
  logic [bst_pkg::EVT_W-1:0]  evt_set;      // Events this cycle
  logic [31:0]                rd_value;     // Read value of the index
  logic                       rd_hit;       // Index is mapped
  logic [bst_pkg::EVT_W-1:0]  evt_clear;    // Flags cleared by a read

  // Trip counters, one per counted kind
  bst_trip_counters #(
    .N (bst_pkg::NUM_CNT),
    .W (bst_pkg::COUNT_W)
  ) u_counters (
    .clk   (clk),
    .rst   (rst),
    .inc   (cnt_inc),
    .count (cnt_val)
  );

  // Route each trip pulse to its counter by cause
  always_comb begin
    cnt_inc = '0;
    if (trip.valid) begin
      case (trip.cause)
        bst_pkg::CAUSE_INST: begin
          cnt_inc[bst_pkg::EVT_INST] = 1'b1;    // [R11]
        end
        bst_pkg::CAUSE_SHORT: begin
          cnt_inc[bst_pkg::EVT_SHORT] = 1'b1;   // [R12]
        end
        bst_pkg::CAUSE_OVERLOAD: begin
          cnt_inc[bst_pkg::EVT_OVLD] = 1'b1;    // [R13]
        end
        bst_pkg::CAUSE_NEUTRAL: begin
          cnt_inc[bst_pkg::EVT_NEUT] = 1'b1;    // [R14]
        end
        default: begin
          // Ground, extended and reserved trips are not counted here
          cnt_inc = '0;
        end
      endcase
    end
  end

  // Event flags follow the counters; other trips share one flag
  always_comb begin
    evt_set = '0;
    evt_set[bst_pkg::NUM_CNT-1:0] = cnt_inc;
    if (trip.valid && cnt_inc == '0) begin
      evt_set[bst_pkg::EVT_OTHER] = 1'b1;
    end
  end

  // Assemble the profile status word; unlisted bits stay zero
  always_comb begin
    profile_word = '0;                                      // [R15]
    profile_word[bst_pkg::BIT_LIMIT]   = cond.limit_reached; // [R2]
    profile_word[bst_pkg::BIT_ALARM]   = cond.alarm_active;  // [R3]
    profile_word[bst_pkg::BIT_WPROT]   = cond.write_protect; // [R4]
    profile_word[bst_pkg::POS_CAUSE_LO +: 3] =
      state_reg.last_cause;                                  // [R5]
    profile_word[bst_pkg::BIT_LOADSHED] =
      cond.load_shed_alarm;                                  // [R6]
    profile_word[bst_pkg::POS_POSITION +: 2] = cond.position; // [R7]
    profile_word[bst_pkg::POS_SWITCH +: 2] =
      cond.switch_state;                                     // [R8]
    profile_word[bst_pkg::BIT_SPRING] = cond.spring_charged; // [R9]
    profile_word[bst_pkg::BIT_OVLD_ALARM] =
      cond.overload_alarm;                                   // [R10]
  end

  // Address decode: word aligned, index in bits 9:2, upper bits zero
  assign req_idx = paddr[9:2];
  assign req_ok  = (paddr[1:0] == 2'b00) &&
                   (paddr[ADDR_W-1:10] == '0);

  // A transfer ends on the edge where the master sees pready high
  assign req_commit = psel && penable && state_reg.pready;

  // Read mux; counters are zero-extended into the 16-bit format
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    case (req_idx)
      bst_pkg::IDX_PROFILE_STATUS: begin
        rd_value[bst_pkg::REG_W-1:0] = profile_word;        // [R1]
      end
      bst_pkg::IDX_INST_TRIP_COUNT: begin
        rd_value[bst_pkg::COUNT_W-1:0] =
          cnt_val[bst_pkg::EVT_INST];                       // [R11]
      end
      bst_pkg::IDX_SHORT_TRIP_COUNT: begin
        rd_value[bst_pkg::COUNT_W-1:0] =
          cnt_val[bst_pkg::EVT_SHORT];                      // [R12]
      end
      bst_pkg::IDX_OVLD_TRIP_COUNT: begin
        rd_value[bst_pkg::COUNT_W-1:0] =
          cnt_val[bst_pkg::EVT_OVLD];                       // [R13]
      end
      bst_pkg::IDX_NEUT_TRIP_COUNT: begin
        rd_value[bst_pkg::COUNT_W-1:0] =
          cnt_val[bst_pkg::EVT_NEUT];                       // [R14]
      end
      bst_pkg::IDX_EVENT_STATUS: begin
        rd_value[bst_pkg::EVT_W-1:0] = state_reg.evt_stat;
      end
      bst_pkg::IDX_EVENT_MASK: begin
        rd_value[bst_pkg::EVT_W-1:0] = state_reg.evt_mask;
      end
      default: begin
        // Unmapped index answers with an error and zero data
        rd_hit = 1'b0;
      end
    endcase
    if (!req_ok) begin
      rd_hit   = 1'b0;
      rd_value = 32'h0000_0000;
    end
  end

  // A status read clears only the flags it actually returned, so an
  // event that lands between capture and commit survives the read
  always_comb begin
    evt_clear = '0;
    if (req_commit && !pwrite && req_ok &&
        req_idx == bst_pkg::IDX_EVENT_STATUS) begin
      evt_clear = state_reg.evt_shown;
    end
  end

  // Next state: APB phase, capture, commit, events and interrupt
  always_comb begin
    state_next = state_reg;
    case (state_reg.phase)
      bst_pkg::PH_IDLE: begin
        // Access phase seen: raise ready with data one edge later
        if (psel && penable) begin
          state_next.phase   = bst_pkg::PH_ANSWER;
          state_next.pready  = 1'b1;
          state_next.pslverr = !rd_hit;
          state_next.prdata  = pwrite ? 32'h0000_0000 : rd_value;
          state_next.evt_shown =
            (!pwrite && rd_hit) ? state_reg.evt_stat : '0;
        end
      end
      bst_pkg::PH_ANSWER: begin
        // Ready stood for one edge; the master now releases
        state_next.phase   = bst_pkg::PH_IDLE;
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;
      end
      default: begin
        state_next.phase  = bst_pkg::PH_IDLE;
        state_next.pready = 1'b0;
      end
    endcase

    // Only the mask takes writes; the read-only words ignore them
    if (req_commit && pwrite && req_ok &&
        req_idx == bst_pkg::IDX_EVENT_MASK) begin
      state_next.evt_mask = pwdata[bst_pkg::EVT_W-1:0];
    end                                                     // [R15]

    // Remember the cause of each trip for the status word
    if (trip.valid) begin
      state_next.last_cause = trip.cause;                   // [R5]
    end

    // Set wins over a read clear in the same cycle
    state_next.evt_stat = (state_reg.evt_stat & ~evt_clear) | evt_set;

    // Interrupt follows the registered flags and mask
    state_next.irq = |(state_next.evt_stat & state_next.evt_mask);
  end

  // State register; synchronous reset to constants only
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.phase      <= bst_pkg::PH_IDLE;
      state_reg.pready     <= 1'b0;
      state_reg.pslverr    <= 1'b0;
      state_reg.prdata     <= 32'h0000_0000;
      state_reg.irq        <= 1'b0;
      state_reg.evt_mask   <= bst_pkg::MASK_RESET;
      state_reg.evt_stat   <= bst_pkg::EVT_RESET;
      state_reg.evt_shown  <= bst_pkg::EVT_RESET;
      state_reg.last_cause <= bst_pkg::CAUSE_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign prdata  = state_reg.prdata;
  assign pready  = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq     = state_reg.irq;

endmodule : bst_status_bank

// ### sim/bst_status_bank_assertions.sv
// Checker for the APB side and status layout of the breaker status bank
`timescale 1ns/1ps
module bst_checker #(
  parameter int ADDR_W = 12                  // APB address width
) (
  input wire logic              clk,         // System clock
  input wire logic              rst,         // Synchronous reset
  input wire logic              psel,        // APB select
  input wire logic              penable,     // APB access phase
  input wire logic              pwrite,      // APB direction
  input wire logic [ADDR_W-1:0] paddr,       // APB byte address
  input wire logic [31:0]       pwdata,      // APB write data
  input wire logic [31:0]       prdata,      // APB read data
  input wire logic              pready,      // APB ready
  input wire logic              pslverr,     // APB error
  input wire bst_pkg::bst_cond_t cond,       // Live conditions
  input wire bst_pkg::bst_trip_t trip,       // Trip pulse
  input wire logic              irq          // Interrupt
);
  // All checks share one clock and one reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Status read seen at the answer edge
  wire logic st_rd = pready && !pwrite && paddr == 12'h368;

  // Every access phase is answered after exactly one wait state
  a_ready_one_wait: assert property (
    $rose(penable) && psel |=> pready)
    else $error("pready late after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_no_sel_idle: assert property (!psel |=> !pready)
    else $error("pready without select");
  a_err_misaligned: assert property (
    pready && (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0)
    |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  // Data answered one edge after capture, so compare with past levels
  a_flags_live: assert property (
    st_rd |-> prdata[0] == $past(cond.limit_reached)
    && prdata[1] == $past(cond.alarm_active)
    && prdata[2] == $past(cond.write_protect)
    && prdata[7] == $past(cond.load_shed_alarm)
    && prdata[14] == $past(cond.spring_charged)
    && prdata[15] == $past(cond.overload_alarm))
    else $error("status flags differ from conditions");
  a_fields_live: assert property (
    st_rd |-> prdata[9:8] == $past(cond.position)
    && prdata[11:10] == $past(cond.switch_state))
    else $error("position or switching field wrong");
  a_rsvd_zero: assert property (
    st_rd |-> !pslverr && prdata[3] == 1'b0
    && prdata[13:12] == 2'h0 && prdata[31:16] == 16'h0)
    else $error("reserved status bits set");
  a_count_range: assert property (
    pready && !pwrite && paddr >= 12'h36C
    && paddr <= 12'h378 && paddr[1:0] == 2'h0
    |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("counter beyond eight bits");
  // Only aligned words; a misaligned write is refused with an error
  a_ro_write: assert property (
    pready && pwrite && paddr >= 12'h368
    && paddr <= 12'h378 && paddr[1:0] == 2'h0
    |-> !pslverr && prdata == 32'h0)
    else $error("write to read-only word answered wrongly");
endmodule : bst_checker

bind bst_status_bank bst_checker #(.ADDR_W(ADDR_W)) chk (.clk(clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cond(cond), .trip(trip), .irq(irq));

// ### sim/bst_apb_master.sv
// Remote master model issuing APB transfers to the status bank
`timescale 1ns/1ps
module bst_apb_master (
  input  wire logic        clk,      // System clock
  output logic             psel,     // APB select
  output logic             penable,  // APB access phase
  output logic             pwrite,   // APB direction
  output logic [11:0]      paddr,    // APB byte address
  output logic [31:0]      pwdata,   // APB write data
  input  wire logic [31:0] prdata,   // APB read data
  input  wire logic        pready,   // APB ready
  input  wire logic        pslverr   // APB error
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // One transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the bench's timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : bst_apb_master

// ### sim/tb_breaker_status_trip_counters.sv
// Self-checking bench for the breaker status bank
`timescale 1ns/1ps
module tb_breaker_status_trip_counters;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]        paddr;       // Byte address
  logic [31:0]        pwdata;      // Write data
  logic [31:0]        prdata;      // Read data
  logic [31:0]        rd;          // Last value read
  logic               er;          // Last error flag
  bst_pkg::bst_cond_t cond;        // Driven conditions
  bst_pkg::bst_trip_t trip;        // Driven trip pulse
  logic [2:0]         last_cause;  // Expected last cause
  logic [7:0]         cnt [4];     // Expected counters
  int error_cnt, checks_done, cyc;

  bst_apb_master mst (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bst_status_bank uut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond),
    .trip(trip), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard; the whole run needs under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    mst.xfer(1'b0, a, 32'h0, rd, er);
    chk({31'h0, er}, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  // Expected status word built from the driven conditions
  function automatic logic [31:0] st_exp();
    return {16'h0, cond.overload_alarm, cond.spring_charged, 2'b00,
            cond.switch_state, cond.position, cond.load_shed_alarm,
            last_cause, 1'b0, cond.write_protect, cond.alarm_active,
            cond.limit_reached};
  endfunction : st_exp

  // One-cycle trip pulse; counters tracked for the four counted causes
  task automatic pulse(input logic [2:0] c);
    @(posedge clk);
    trip <= '{1'b1, bst_pkg::bst_cause_t'(c)};
    @(posedge clk);
    trip <= '{1'b0, bst_pkg::CAUSE_NONE};
    last_cause = c;
    case (c)
      3'h2: cnt[0] = (cnt[0] == 8'hFF) ? 8'hFF : cnt[0] + 8'h01;
      3'h3: cnt[1] = (cnt[1] == 8'hFF) ? 8'hFF : cnt[1] + 8'h01;
      3'h1: cnt[2] = (cnt[2] == 8'hFF) ? 8'hFF : cnt[2] + 8'h01;
      3'h6: cnt[3] = (cnt[3] == 8'hFF) ? 8'hFF : cnt[3] + 8'h01;
      default: ;
    endcase
  endtask : pulse

  task automatic rd_counts();
    for (int i = 0; i < 4; i++) begin
      rd_chk(12'h36C + 12'(4*i), {24'h0, cnt[i]});
    end
  endtask : rd_counts

  // Every position and switching code, flags toggled alongside
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cond <= {{4{i[0]}}, 2'(i), 2'(3 - i), ~i[0], i[0]};
      @(posedge clk);
      rd_chk(12'h368, st_exp());
    end
  endtask : t_status

  // Every cause code lands in the status word; counted ones counted
  task automatic t_trips();
    for (int c = 0; c < 8; c++) begin
      pulse(3'(c));
      rd_chk(12'h368, st_exp());
    end
    rd_counts();
  endtask : t_trips

  // Instantaneous count stops at its ceiling
  task automatic t_saturate();
    repeat (256) pulse(3'h2);
    rd_chk(12'h36C, 32'hFF);
    rd_counts();
  endtask : t_saturate

  // Writes to the read-only words change nothing and raise no error
  task automatic t_write_ro();
    for (int i = 0; i < 5; i++) begin
      mst.xfer(1'b1, 12'h368 + 12'(4 * i), 32'hFFFF, rd, er);
      chk({31'h0, er}, 32'h0);
      chk(rd, 32'h0);
    end
    rd_chk(12'h368, st_exp());
    rd_counts();
  endtask : t_write_ro

  // Flag raised, masked, unmasked and cleared; bad addresses refused
  task automatic t_irq();
    mst.xfer(1'b0, 12'h3C0, 32'h0, rd, er);
    chk(rd, 32'h1F);
    pulse(3'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    mst.xfer(1'b1, 12'h3C4, 32'h1F, rd, er);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(12'h3C0, 32'h02);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    mst.xfer(1'b0, 12'h100, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Misaligned word and address above the decoded range
    mst.xfer(1'b0, 12'h36A, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    mst.xfer(1'b0, 12'hB68, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_irq

  // Mid-run reset brings counters and last cause back to zero
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    last_cause = 3'h0;
    cnt = '{default: 8'h00};
    rd_chk(12'h368, st_exp());
    rd_counts();
  endtask : t_reset

  task automatic results();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    rst = 1'b1;
    cond = '0;
    trip = '0;
    last_cause = 3'h0;
    cnt = '{default: 8'h00};
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h368, 32'h0);
    rd_counts();
    t_status();
    t_trips();
    t_saturate();
    t_write_ro();
    t_irq();
    t_reset();
    results();
  end
endmodule : tb_breaker_status_trip_counters
